//--- rtl/wsr_pkg.sv
package wsr_pkg;

  // ****************************************************************
  // timing base
  // ****************************************************************
  localparam int unsigned CLK_KHZ         = 10000;
  localparam int unsigned STARTUP_US      = 300;
  localparam int unsigned CLASSIFY_US     = 450;
  localparam int unsigned DELAY_FLOAT_US  = 10000;
  localparam int unsigned DELAY_PULLUP_US = 200000;

  // least times round up to whole cycles
  localparam int unsigned STARTUP_CYC  = (STARTUP_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned CLASSIFY_CYC = (CLASSIFY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned FLOAT_CYC    = (DELAY_FLOAT_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned PULLUP_CYC   = (DELAY_PULLUP_US * CLK_KHZ + 999) / 1000;

  localparam int unsigned CNT_W = 22;

  // ****************************************************************
  // synchroniser input order and reset levels
  // ****************************************************************
  localparam int unsigned IN_W       = 7;
  localparam int unsigned IN_BELOW   = 0;
  localparam int unsigned IN_ABOVE   = 1;
  localparam int unsigned IN_LOW_HYS = 2;
  localparam int unsigned IN_HI_HYS  = 3;
  localparam int unsigned IN_MAN_N   = 4;
  localparam int unsigned IN_LOCK    = 5;
  localparam int unsigned IN_PIN_HI  = 6;
  // manual reset idles high as if pulled up; all else idles low
  localparam logic [IN_W-1:0] IN_RST = 7'h10;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_FLOAT,
    MODE_PULLUP,
    MODE_CAP
  } wsr_mode_e;

  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_HOLD,
    ST_CLASS_PD,
    ST_CLASS_CHG,
    ST_DELAY,
    ST_RELEASED
  } wsr_state_e;

endpackage

//--- rtl/wsr_sync.sv
`timescale 1ns/1ns

// ****************************************************************
// three-stage synchroniser, output moves when stages two and three agree
// ****************************************************************
module wsr_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // asynchronous levels in, clean levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;

  // per bit: accept only a value seen on two successive samples
  always_comb begin
    for (int i = 0; i < int'(WIDTH); i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : o_sync[i];
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q   <= RST_VAL;
      s2_q   <= RST_VAL;
      s3_q   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      s1_q   <= i_async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      o_sync <= out_d;
    end
  end

endmodule

//--- rtl/wsr_reset_logic.sv
`timescale 1ns/1ns

// Behaviour
// [R1] outside window pulls reset output low
// [R2] inside window, no cause: output released
// [R3] window valid uses hysteresis on both sides
// [R4] manual reset low asserts reset output
// [R5] release after manual reset only post delay
// [R6] manual reset input idles high when open
// [R7] delay runs only with manual high, inner window
// [R8] manual reset ignored during voltage fault hold
// [R9] reclassify delay pin on each window entry
// [R10] classify pin three ways in 450 us
// [R11] floating, pull-up fixed; capacitor programmable
// [R12] supply lockout holds reset output low
// [R13] downstream ignores output below minimum supply
// [R14] output tracks only after startup plus delay
// [R15] output only pulls low or releases
// [R16] manual low pulse of 1 us recognised
// [R17] capacitor discharged in reset, charged after
// [R18] grounded delay pin latches reset low
// [R19] raising delay pin releases without delay
// [R20] analog results enter through synchronisers
// [R21] lost condition restarts delay from zero
module wsr_reset_logic #(
  parameter int unsigned CLASSIFY_CYC = wsr_pkg::CLASSIFY_CYC,
  parameter int unsigned FLOAT_CYC    = wsr_pkg::FLOAT_CYC,
  parameter int unsigned PULLUP_CYC   = wsr_pkg::PULLUP_CYC
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // window comparators
  input  wire logic i_below_low_trip,
  input  wire logic i_above_high_trip,
  input  wire logic i_above_low_hys,
  input  wire logic i_below_high_hys,
  // manual reset and supply
  input  wire logic i_manual_reset_n,
  input  wire logic i_supply_lockout,
  // delay-configuration pin comparator (above cap trip level)
  input  wire logic i_delay_pin_high,
  // open-drain reset output
  output logic      o_reset_n_o,
  output logic      o_reset_n_oe,
  // delay-configuration pin drive
  output logic      o_delay_pin_pd,
  output logic      o_cap_charge_en,
  // status
  output logic [1:0] o_delay_mode
);

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [wsr_pkg::IN_W-1:0] in_s;

  // all analog decisions are sampled on the internal clock [R20]
  wsr_sync #(
    .WIDTH   (wsr_pkg::IN_W),
    .RST_VAL (wsr_pkg::IN_RST)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_delay_pin_high, i_supply_lockout, i_manual_reset_n,
               i_below_high_hys, i_above_low_hys, i_above_high_trip,
               i_below_low_trip}),
    .o_sync  (in_s)
  );

  logic man_n;
  logic lockout;
  logic pin_hi;
  assign man_n   = in_s[wsr_pkg::IN_MAN_N];   // [R6] [R16]
  assign lockout = in_s[wsr_pkg::IN_LOCK];
  assign pin_hi  = in_s[wsr_pkg::IN_PIN_HI];

  // ****************************************************************
  // window with hysteresis
  // ****************************************************************
  logic win_q;
  logic win_d;
  logic need_class_q;
  logic need_class_d;

  // valid only inside the narrowed window, lost only past a trip level;
  // hovering near a trip level therefore cannot toggle it [R3]
  always_comb begin
    win_d = win_q;
    if (in_s[wsr_pkg::IN_BELOW] || in_s[wsr_pkg::IN_ABOVE]) begin
      win_d = 1'b0;                                  // [R1]
    end else if (in_s[wsr_pkg::IN_LOW_HYS] && in_s[wsr_pkg::IN_HI_HYS]) begin
      win_d = 1'b1;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  wsr_pkg::wsr_state_e state_q;
  wsr_pkg::wsr_state_e state_d;
  wsr_pkg::wsr_mode_e  mode_q;
  wsr_pkg::wsr_mode_e  mode_d;
  logic [wsr_pkg::CNT_W-1:0] cnt_q;
  logic [wsr_pkg::CNT_W-1:0] cnt_d;
  logic go;

  // every cause for holding reset, apart from startup
  assign go = win_q && man_n && !lockout;  // [R7]

  function automatic logic cnt_done(input logic [wsr_pkg::CNT_W-1:0] c,
                                    input int unsigned lim);
    cnt_done = ({10'h000, c} >= 32'(lim) - 32'h0000_0001);
  endfunction

  function automatic int unsigned fixed_lim(input wsr_pkg::wsr_mode_e m);
    fixed_lim = (m == wsr_pkg::MODE_PULLUP) ? PULLUP_CYC : FLOAT_CYC;
  endfunction

  always_comb begin
    state_d      = state_q;
    mode_d       = mode_q;
    cnt_d        = cnt_q + 22'h000001;
    need_class_d = need_class_q;
    unique case (state_q)
      // output held until the supply has been good long enough [R14]
      wsr_pkg::ST_STARTUP: begin
        if (cnt_done(cnt_q, wsr_pkg::STARTUP_CYC)) begin
          state_d = wsr_pkg::ST_HOLD;
          cnt_d   = '0;
        end
      end
      // asserted; manual level only matters once voltage is good [R8]
      wsr_pkg::ST_HOLD: begin
        cnt_d = '0;
        if (go) begin
          state_d = need_class_q ? wsr_pkg::ST_CLASS_PD   // [R9]
                                 : wsr_pkg::ST_DELAY;
        end
      end
      // phase one: pin pulled down, a resistor still reads high; both
      // phases always run, so every wiring costs the same time [R10]
      wsr_pkg::ST_CLASS_PD: begin
        if (cnt_done(cnt_q, CLASSIFY_CYC / 2)) begin
          cnt_d   = '0;
          mode_d  = pin_hi ? wsr_pkg::MODE_PULLUP : wsr_pkg::MODE_CAP;
          state_d = wsr_pkg::ST_CLASS_CHG;
        end
      end
      // phase two: charge current on, an open pin rises fast [R10]
      wsr_pkg::ST_CLASS_CHG: begin
        if (cnt_done(cnt_q, CLASSIFY_CYC - CLASSIFY_CYC / 2)) begin
          cnt_d        = '0;
          if (mode_q == wsr_pkg::MODE_CAP && pin_hi) begin
            mode_d = wsr_pkg::MODE_FLOAT;
          end
          need_class_d = 1'b0;
          state_d      = wsr_pkg::ST_DELAY;
        end
      end
      // release delay; cap mode waits for the pin trip, so a grounded
      // pin never releases until raised, and then at once [R11]
      wsr_pkg::ST_DELAY: begin
        if (mode_q == wsr_pkg::MODE_CAP) begin
          if (pin_hi) begin
            state_d = wsr_pkg::ST_RELEASED;          // [R17] [R18] [R19]
          end
        end else if (cnt_done(cnt_q, fixed_lim(mode_q))) begin
          state_d = wsr_pkg::ST_RELEASED;            // [R5]
        end
      end
      wsr_pkg::ST_RELEASED: begin
        cnt_d = '0;                                  // [R2]
      end
    endcase
    // any lost condition returns to hold; count restarts there [R21]
    if (state_q != wsr_pkg::ST_STARTUP && !go) begin
      state_d = wsr_pkg::ST_HOLD;                    // [R1] [R4] [R12]
      cnt_d   = '0;
    end
    // a window loss wins over a classification ending in the same cycle
    if (!win_q) begin
      need_class_d = 1'b1;                           // [R9]
    end
  end

  // ****************************************************************
  // output drive
  // ****************************************************************
  logic rst_oe_d;
  logic pd_d;
  logic chg_d;

  // open drain: enable means pull low, never drive high [R15]
  always_comb begin
    rst_oe_d = (state_d != wsr_pkg::ST_RELEASED);
    pd_d     = (state_d == wsr_pkg::ST_CLASS_PD) ||
               (rst_oe_d && state_d != wsr_pkg::ST_DELAY &&
                state_d != wsr_pkg::ST_CLASS_CHG &&
                mode_q == wsr_pkg::MODE_CAP);       // [R17]
    chg_d    = (state_d == wsr_pkg::ST_CLASS_CHG) ||
               (state_d == wsr_pkg::ST_DELAY &&
                mode_d == wsr_pkg::MODE_CAP);        // [R17]
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_q           <= 1'b0;
      need_class_q    <= 1'b1;
      state_q         <= wsr_pkg::ST_STARTUP;
      mode_q          <= wsr_pkg::MODE_FLOAT;
      cnt_q           <= '0;
      o_reset_n_o     <= 1'b0;
      o_reset_n_oe    <= 1'b1;
      o_delay_pin_pd  <= 1'b0;
      o_cap_charge_en <= 1'b0;
      o_delay_mode    <= 2'h0;
    end else begin
      win_q           <= win_d;
      need_class_q    <= need_class_d;
      state_q         <= state_d;
      mode_q          <= mode_d;
      cnt_q           <= cnt_d;
      o_reset_n_o     <= 1'b0;
      o_reset_n_oe    <= rst_oe_d;
      o_delay_pin_pd  <= pd_d;
      o_cap_charge_en <= chg_d;
      o_delay_mode    <= mode_d;
    end
  end

endmodule

//--- tb/wsr_reset_logic_props.sv
`timescale 1ns/1ns
// ****
// reset logic checker
// ****
module wsr_chk #(
  parameter int unsigned FLOAT_CYC  = 40,
  parameter int unsigned PULLUP_CYC = 80
) (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_below_low_trip,
  input wire logic       i_above_high_trip,
  input wire logic       i_manual_reset_n,
  input wire logic       i_supply_lockout,
  input wire logic       i_delay_pin_high,
  input wire logic       o_reset_n_o,
  input wire logic       o_reset_n_oe,
  input wire logic       o_delay_pin_pd,
  input wire logic       o_cap_charge_en,
  input wire logic [1:0] o_delay_mode
);
  logic [21:0] hi_cnt_q;
  logic [11:0] up_cnt_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // run length of the pull and time since power-on
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_q <= 22'h0;
      up_cnt_q <= 12'h0;
    end else begin
      hi_cnt_q <= o_reset_n_oe ? hi_cnt_q + 22'h1 : 22'h0;
      up_cnt_q <= up_cnt_q + {11'h0, up_cnt_q != 12'hFFF};
    end
  end
  sequence s_release;
    $fell(o_reset_n_oe);
  endsequence
  a_never_high:
    assert property (o_reset_n_o == 1'b0) else $error("line driven high");
  a_under_pulls:
    assert property (i_below_low_trip [*8] |-> o_reset_n_oe)
    else $error("undervoltage not pulled");
  a_over_pulls:
    assert property (i_above_high_trip [*8] |-> o_reset_n_oe)
    else $error("overvoltage not pulled");
  a_lock_pulls:
    assert property (i_supply_lockout [*8] |-> o_reset_n_oe)
    else $error("lockout not pulled");
  a_manual_pulls:
    assert property (!i_manual_reset_n [*8] |-> o_reset_n_oe)
    else $error("manual reset not pulled");
  a_release_cause:
    assert property (s_release |-> $past(i_manual_reset_n, 8) &&
                     !$past(i_supply_lockout, 8))
    else $error("release with cause present");
  a_fixed_delay:
    assert property (s_release and o_delay_mode != 2'h2 |->
      hi_cnt_q >= (o_delay_mode == 2'h1 ? PULLUP_CYC : FLOAT_CYC))
    else $error("release before delay");
  a_cap_release:
    assert property (s_release and o_delay_mode == 2'h2 |->
                     $past(i_delay_pin_high, 4))
    else $error("cap release before trip");
  a_pin_drive:
    assert property (!(o_delay_pin_pd && o_cap_charge_en))
    else $error("pin charged and discharged");
  a_startup_hold:
    assert property (up_cnt_q < wsr_pkg::STARTUP_CYC |-> o_reset_n_oe)
    else $error("released during startup");
endmodule
bind wsr_reset_logic wsr_chk #(
  .FLOAT_CYC (FLOAT_CYC),
  .PULLUP_CYC(PULLUP_CYC)
) u_chk (
  .i_mclk           (i_mclk),
  .i_rst_n          (i_rst_n),
  .i_below_low_trip (i_below_low_trip),
  .i_above_high_trip(i_above_high_trip),
  .i_manual_reset_n (i_manual_reset_n),
  .i_supply_lockout (i_supply_lockout),
  .i_delay_pin_high (i_delay_pin_high),
  .o_reset_n_o      (o_reset_n_o),
  .o_reset_n_oe     (o_reset_n_oe),
  .o_delay_pin_pd   (o_delay_pin_pd),
  .o_cap_charge_en  (o_cap_charge_en),
  .o_delay_mode     (o_delay_mode)
);

//--- tb/wsr_far_model.sv
`timescale 1ns/1ns
// ****
// reset line and delay pin wiring
// ****
module wsr_far_model (
  input  wire logic       i_mclk,
  input  wire logic       i_o,
  input  wire logic       i_oe,
  input  wire logic       i_pd,
  input  wire logic       i_chg,
  input  wire logic [1:0] i_cfg,
  output logic            o_line,
  output logic            o_pin_high
);
  localparam int unsigned CAP_CYC = 30;
  int unsigned cap_q;
  // external pull-up wins unless the device pulls low
  assign o_line = i_oe ? i_o : 1'b1;
  // capacitor: pulldown empties it, charge current fills it
  always_ff @(posedge i_mclk) begin
    cap_q <= i_pd ? 0 : cap_q + i_chg;
  end
  // pin level: 0 float, 1 pull-up or unlatch drive, 2 cap, 3 ground
  always_comb begin
    case (i_cfg)
      2'h0:    o_pin_high = i_chg;
      2'h1:    o_pin_high = 1'b1;
      2'h2:    o_pin_high = cap_q >= CAP_CYC;
      default: o_pin_high = 1'b0;
    endcase
  end
endmodule

//--- tb/wsr_reset_logic_tb.sv
`timescale 1ns/1ns
module wsr_reset_logic_tb;
  localparam int CL = 20;
  localparam int FL = 40;
  localparam int PU = 80;
  logic mclk = 0;
  logic rst_n = 0;
  logic [3:0] win = 4'h3; // below, above, low hys, high hys
  logic man_n = 1;
  logic lock = 0;
  logic [1:0] cfg = 2'h0;
  logic line, pin, o, oe, pd, chg;
  logic [1:0] mode;
  int err_total = 0;
  int compares = 0;
  int n;
  always #50 mclk = ~mclk;
  wsr_reset_logic #(.CLASSIFY_CYC(CL), .FLOAT_CYC(FL), .PULLUP_CYC(PU)) dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_below_low_trip(win[3]),
    .i_above_high_trip(win[2]), .i_above_low_hys(win[1]),
    .i_below_high_hys(win[0]), .i_manual_reset_n(man_n),
    .i_supply_lockout(lock), .i_delay_pin_high(pin), .o_reset_n_o(o),
    .o_reset_n_oe(oe), .o_delay_pin_pd(pd), .o_cap_charge_en(chg),
    .o_delay_mode(mode));
  wsr_far_model far (.i_mclk(mclk), .i_o(o), .i_oe(oe), .i_pd(pd),
    .i_chg(chg), .i_cfg(cfg), .o_line(line), .o_pin_high(pin));
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #10;
  endtask
  // bounded wait for a line level, cycles taken in n
  task automatic wait_line(input logic v, input int lim);
    n = 0;
    while (line !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(line, v);
  endtask
  // fault then good window with a new pin wiring
  task automatic fault(input logic [3:0] f, input logic [1:0] c);
    cfg = c;
    win = f;
    wait_line(1'b0, 8);
    win = 4'h3;
    wait_line(1'b1, 400);
  endtask
  task automatic t_startup;
    tick(2900);
    chk(line, 1'b1 ^ 1'b1);
    wait_line(1'b1, 400);
    chk(n >= wsr_pkg::STARTUP_CYC + CL + FL - 2900, 1);
    chk(mode, 2'h0);
  endtask
  task automatic t_fixed;
    fault(4'h8, 2'h1);
    chk(mode, 2'h1);
    chk(n >= CL + PU, 1);
    fault(4'h4, 2'h0);
    chk(mode, 2'h0);
  endtask
  task automatic t_hyst;
    win = 4'h8;
    tick(10);
    win = 4'h1;
    tick(200);
    chk(line, 1'b0);
    win = 4'h3;
    wait_line(1'b1, 400);
  endtask
  task automatic t_manual;
    cfg = 2'h1;
    man_n = 0;
    tick(10);
    chk(line, 1'b0);
    man_n = 1;
    tick(20);
    lock = 1;
    tick(10);
    chk(line, 1'b0);
    lock = 0;
    wait_line(1'b1, 200);
    chk(n >= FL, 1);
    chk(mode, 2'h0);
  endtask
  task automatic t_cap;
    fault(4'h8, 2'h2);
    chk(mode, 2'h2);
    chk(n >= CL + 30, 1);
    man_n = 0;
    tick(10);
    chk(pd, 1'b1);
    man_n = 1;
    wait_line(1'b1, 200);
  endtask
  task automatic t_latch;
    cfg = 2'h3;
    win = 4'h4;
    tick(10);
    win = 4'h3;
    tick(300);
    chk(line, 1'b0);
    cfg = 2'h1;
    wait_line(1'b1, 8);
  endtask
  task automatic finish_test;
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under 8000 cycles
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    // line is left unjudged while power-on reset holds
    tick(6);
    rst_n = 1;
    t_startup();
    t_fixed();
    t_hyst();
    t_manual();
    t_cap();
    t_latch();
    finish_test();
  end
endmodule
